// ---- multi_pin_consts.svh ----
/*
 * Constants for the multifunction pin router: synchroniser layout and
 * the index of each bit in the synchronised input vector.
 * Assumes it is included by bare name from the router module.
 */
`ifndef MULTI_PIN_CONSTS_SVH
`define MULTI_PIN_CONSTS_SVH

// ----------------------------------------------------------------------
// pin counts and synchroniser depth
// ----------------------------------------------------------------------
`define MP_NUM_PINS 7
`define MP_NUM_GEN 5
`define MP_SYNC_STAGES 3

// ----------------------------------------------------------------------
// bit positions in the synchronised input vector
// ----------------------------------------------------------------------
`define MP_SYNC_WIDTH 14
`define MP_SYNC_PIN_LSB 0
`define MP_SYNC_GLOBAL_RESET 7
`define MP_SYNC_BUS_RESET 8
`define MP_SYNC_SUSPEND 9
`define MP_SYNC_DETECT_A 10
`define MP_SYNC_DETECT_B 11
`define MP_SYNC_SPEAKER 12
`define MP_SYNC_AUDIO 13

// ----------------------------------------------------------------------
// pins claimed by the serial EEPROM loader, and the serial IRQ and clock-run pins
// ----------------------------------------------------------------------
`define MP_SDA_PIN 1
`define MP_SCL_PIN 4
`define MP_SERIRQ_PIN 3
`define MP_CLKRUN_PIN 6

`endif

// ---- multi_pin_pkg.sv ----
/*
 * Types shared by the multifunction pin router.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package multi_pin_pkg;

    // function carried by one multifunction pin
    typedef enum logic [3:0] {
        FN_PAR_IRQ,
        FN_INTA,
        FN_GEN_IN,
        FN_GEN_OUT,
        FN_ACTIVITY,
        FN_VIDEO,
        FN_AUDIO_PWM,
        FN_GPE,
        FN_POWER_STATE,
        FN_RING,
        FN_LOCK,
        FN_SERIRQ,
        FN_CLKRUN
    } mux_fn_t;

    typedef mux_fn_t [6:0] pin_sel_t;

    // routing configuration written by software
    typedef struct packed {
        logic pme_select;
        pin_sel_t sel;
    } route_cfg_t;

    // internal function sources that may reach a pin
    typedef struct packed {
        logic inta;
        logic [4:0] gen_out;
        logic activity;
        logic video;
        logic audio_pwm;
        logic general_purpose_event;
        logic power_state;
        logic ring;
        logic [6:0] par_irq;
        logic serirq_out;
        logic serirq_oe;
        logic clkrun_out;
        logic clkrun_oe;
    } fn_src_t;

endpackage : multi_pin_pkg

// ---- multi_pin_router.sv ----
/*
 * Multifunction pin router: steers seven two-way pins to internal
 * functions, lends two of them to the serial EEPROM loader after a
 * global reset, combines card audio into the speaker output and drives
 * the ring-indicate / power-event pin.
 * Assumes pins arrive asynchronously and that the loader, interrupt and
 * clock-run logic sit on i_clk_sys.
 */
`timescale 1ns/10ps
`include "multi_pin_consts.svh"

module multi_pin_router (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset,
    // external reset, suspend and detect pins
    input wire logic i_global_reset,
    input wire logic i_bus_reset,
    input wire logic i_suspend,
    input wire logic i_serial_detect_a,
    input wire logic i_serial_detect_b,
    // routing configuration
    input wire logic i_route_wr,
    input wire multi_pin_pkg::route_cfg_t i_route_data,
    output multi_pin_pkg::route_cfg_t o_route_cfg,
    // internal function sources
    input wire multi_pin_pkg::fn_src_t i_src,
    // internal function results
    output logic [4:0] o_general_input,
    output logic o_pci_lock,
    output logic o_serirq_in,
    output logic o_clkrun_in,
    // EEPROM loader
    input wire logic i_load_done,
    input wire logic i_sda_drive_low,
    input wire logic i_scl_drive_low,
    input wire logic i_pme,
    output logic o_eeprom_mode,
    output logic o_sda_in,
    output logic o_scl_in,
    // multifunction pins
    input wire logic [6:0] i_pin,
    output logic [6:0] o_pin,
    output logic [6:0] o_pin_oe,
    // card audio and miscellaneous outputs
    input wire logic i_card_speaker_input,
    input wire logic i_card_audio_input,
    output logic o_speaker_output,
    output logic o_ring_pme
);

    // ------------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------------
    logic [`MP_SYNC_WIDTH-1:0] raw_in;
    logic [`MP_SYNC_WIDTH-1:0] sync_1;
    logic [`MP_SYNC_WIDTH-1:0] sync_2;
    logic [`MP_SYNC_WIDTH-1:0] sync_3;
    logic [`MP_SYNC_WIDTH-1:0] filt;

    assign raw_in = {i_card_audio_input, i_card_speaker_input, i_serial_detect_b,
                     i_serial_detect_a, i_suspend, i_bus_reset, i_global_reset, i_pin};

    // a change only counts once stages two and three agree
    genvar s;
    generate
        for (s = 0; s < `MP_SYNC_WIDTH; s++)
        begin : g_sync
            always_ff @(posedge i_clk_sys or posedge i_reset)
            begin
                if (i_reset)
                begin
                    sync_1[s] <= 1'b0;
                    sync_2[s] <= 1'b0;
                    sync_3[s] <= 1'b0;
                    filt[s] <= 1'b0;
                end
                else
                begin
                    sync_1[s] <= raw_in[s];
                    sync_2[s] <= sync_1[s];
                    sync_3[s] <= sync_2[s];
                    if (sync_2[s] == sync_3[s])
                        filt[s] <= sync_3[s];
                end
            end
        end
    endgenerate

    logic [6:0] pin_in;
    logic global_rst;
    logic bus_rst;
    logic suspend;
    logic global_rst_q;

    assign pin_in = filt[`MP_SYNC_PIN_LSB +: `MP_NUM_PINS];
    assign global_rst = filt[`MP_SYNC_GLOBAL_RESET];
    assign bus_rst = filt[`MP_SYNC_BUS_RESET];
    assign suspend = filt[`MP_SYNC_SUSPEND];

    // ------------------------------------------------------------------
    // routing register
    // ------------------------------------------------------------------
    localparam multi_pin_pkg::pin_sel_t SEL_DEFAULT = multi_pin_pkg::pin_sel_t'({
        multi_pin_pkg::FN_CLKRUN, multi_pin_pkg::FN_GEN_IN, multi_pin_pkg::FN_GEN_IN,
        multi_pin_pkg::FN_SERIRQ, multi_pin_pkg::FN_GEN_IN, multi_pin_pkg::FN_GEN_IN,
        multi_pin_pkg::FN_GEN_IN});

    logic pin_reset;

    assign pin_reset = (global_rst || bus_rst) && !suspend;

    always_ff @(posedge i_clk_sys or posedge i_reset)
    begin
        if (i_reset)
        begin
            o_route_cfg.sel <= SEL_DEFAULT;
            o_route_cfg.pme_select <= 1'b0;
        end
        else if (pin_reset)
        begin
            o_route_cfg.sel <= SEL_DEFAULT;
            o_route_cfg.pme_select <= 1'b0;
        end
        else if (i_route_wr)
        begin
            o_route_cfg <= i_route_data;
        end
    end

    // ------------------------------------------------------------------
    // serial EEPROM claim after global reset
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk_sys or posedge i_reset)
    begin
        if (i_reset)
            global_rst_q <= 1'b0;
        else
            global_rst_q <= global_rst;
    end

    // the capture wins over a loader finish arriving in the same cycle
    always_ff @(posedge i_clk_sys or posedge i_reset)
    begin
        if (i_reset)
            o_eeprom_mode <= 1'b0;
        else if (global_rst_q && !global_rst)
            o_eeprom_mode <= filt[`MP_SYNC_DETECT_A] && filt[`MP_SYNC_DETECT_B];
        else if (i_load_done)
            o_eeprom_mode <= 1'b0;
    end

    // ------------------------------------------------------------------
    // per-pin legality and drive
    // ------------------------------------------------------------------
    // pins 0,1,2,4,5 carry general lines 0..4; pins 3 and 6 carry none
    function automatic logic [2:0] gen_index(input int pin);
        gen_index = (pin > 3) ? 3'(pin - 1) : 3'(pin);
    endfunction : gen_index

    function automatic logic fn_legal(input int pin, input multi_pin_pkg::mux_fn_t f);
        fn_legal = 1'b0;
        unique case (f)
            multi_pin_pkg::FN_PAR_IRQ: fn_legal = 1'b1;
            multi_pin_pkg::FN_INTA: fn_legal = (pin == 0);
            multi_pin_pkg::FN_SERIRQ: fn_legal = (pin == `MP_SERIRQ_PIN);
            multi_pin_pkg::FN_CLKRUN: fn_legal = (pin == `MP_CLKRUN_PIN);
            multi_pin_pkg::FN_LOCK: fn_legal = (pin == 4);
            multi_pin_pkg::FN_RING: fn_legal = (pin == 2) || (pin == 4);
            multi_pin_pkg::FN_POWER_STATE: fn_legal = (pin == 1) || (pin == 2) ||
                                                    (pin == 4) || (pin == 5);
            multi_pin_pkg::FN_GEN_IN, multi_pin_pkg::FN_GEN_OUT,
            multi_pin_pkg::FN_ACTIVITY, multi_pin_pkg::FN_VIDEO,
            multi_pin_pkg::FN_AUDIO_PWM, multi_pin_pkg::FN_GPE:
                fn_legal = (pin != `MP_SERIRQ_PIN) && (pin != `MP_CLKRUN_PIN);
            default: fn_legal = 1'b0;
        endcase
    endfunction : fn_legal

    logic [4:0] gen_in_hit;

    genvar p;
    generate
        for (p = 0; p < `MP_NUM_PINS; p++)
        begin : g_pin
            logic next_out;
            logic next_oe;
            multi_pin_pkg::mux_fn_t f;
            logic eeprom_pin;

            assign f = o_route_cfg.sel[p];
            assign eeprom_pin = o_eeprom_mode &&
                                ((p == `MP_SDA_PIN) || (p == `MP_SCL_PIN));

            always_comb
            begin
                next_out = 1'b0;
                next_oe = 1'b0;
                if (eeprom_pin)
                begin
                    // open drain: only ever pulls low
                    next_oe = (p == `MP_SDA_PIN) ? i_sda_drive_low : i_scl_drive_low;
                end
                else if (fn_legal(p, f))
                begin
                    unique case (f)
                        multi_pin_pkg::FN_PAR_IRQ:
                        begin
                            next_out = i_src.par_irq[p];
                            next_oe = 1'b1;
                        end
                        multi_pin_pkg::FN_INTA: next_oe = i_src.inta;
                        multi_pin_pkg::FN_GEN_OUT:
                        begin
                            next_out = i_src.gen_out[gen_index(p)];
                            next_oe = 1'b1;
                        end
                        multi_pin_pkg::FN_ACTIVITY: {next_oe, next_out} = {1'b1, i_src.activity};
                        multi_pin_pkg::FN_VIDEO: {next_oe, next_out} = {1'b1, i_src.video};
                        multi_pin_pkg::FN_AUDIO_PWM: {next_oe, next_out} = {1'b1, i_src.audio_pwm};
                        multi_pin_pkg::FN_GPE: {next_oe, next_out} = {1'b1, i_src.general_purpose_event};
                        multi_pin_pkg::FN_POWER_STATE:
                            {next_oe, next_out} = {1'b1, i_src.power_state};
                        multi_pin_pkg::FN_RING: {next_oe, next_out} = {1'b1, i_src.ring};
                        multi_pin_pkg::FN_SERIRQ:
                            {next_oe, next_out} = {i_src.serirq_oe, i_src.serirq_out};
                        multi_pin_pkg::FN_CLKRUN:
                            {next_oe, next_out} = {i_src.clkrun_oe, i_src.clkrun_out};
                        default:
                        begin
                            next_out = 1'b0;
                            next_oe = 1'b0;
                        end
                    endcase
                end
            end

            always_ff @(posedge i_clk_sys or posedge i_reset)
            begin
                if (i_reset)
                begin
                    o_pin[p] <= 1'b0;
                    o_pin_oe[p] <= 1'b0;
                end
                else
                begin
                    o_pin[p] <= next_out;
                    o_pin_oe[p] <= next_oe;
                end
            end

            if (p != `MP_SERIRQ_PIN && p != `MP_CLKRUN_PIN)
            begin : g_gen
                assign gen_in_hit[gen_index(p)] = !eeprom_pin &&
                    (f == multi_pin_pkg::FN_GEN_IN);
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // inputs returned from the pins
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk_sys or posedge i_reset)
    begin
        if (i_reset)
        begin
            o_general_input <= 5'h00;
            o_pci_lock <= 1'b1;
            o_serirq_in <= 1'b1;
            o_clkrun_in <= 1'b1;
            o_sda_in <= 1'b1;
            o_scl_in <= 1'b1;
        end
        else
        begin
            o_general_input <= gen_in_hit & {pin_in[5:4], pin_in[2:0]};
            o_pci_lock <= (o_route_cfg.sel[4] == multi_pin_pkg::FN_LOCK && !o_eeprom_mode)
                          ? pin_in[4] : 1'b1;
            o_serirq_in <= (o_route_cfg.sel[3] == multi_pin_pkg::FN_SERIRQ) ? pin_in[3] : 1'b1;
            o_clkrun_in <= (o_route_cfg.sel[6] == multi_pin_pkg::FN_CLKRUN) ? pin_in[6] : 1'b1;
            o_sda_in <= o_eeprom_mode ? pin_in[`MP_SDA_PIN] : 1'b1;
            o_scl_in <= o_eeprom_mode ? pin_in[`MP_SCL_PIN] : 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // speaker and ring / power-event outputs
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk_sys or posedge i_reset)
    begin
        if (i_reset)
        begin
            o_speaker_output <= 1'b0;
            o_ring_pme <= 1'b0;
        end
        else
        begin
            o_speaker_output <= filt[`MP_SYNC_SPEAKER] ^ filt[`MP_SYNC_AUDIO];
            o_ring_pme <= o_route_cfg.pme_select ? i_pme : i_src.ring;
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    property p_speaker_xor;
        @(posedge i_clk_sys) disable iff (i_reset)
        ##1 o_speaker_output == $past(filt[`MP_SYNC_SPEAKER] ^ filt[`MP_SYNC_AUDIO]);
    endproperty
    a_speaker_xor: assert property (p_speaker_xor) else $error("speaker not xor");

    property p_suspend_keeps;
        @(posedge i_clk_sys) disable iff (i_reset)
        (suspend && !i_route_wr) |=> $stable(o_route_cfg);
    endproperty
    a_suspend_keeps: assert property (p_suspend_keeps) else $error("cfg lost in suspend");

    property p_reset_clears;
        @(posedge i_clk_sys) disable iff (i_reset)
        pin_reset |=> o_route_cfg.sel == SEL_DEFAULT;
    endproperty
    a_reset_clears: assert property (p_reset_clears) else $error("cfg not reset");

    property p_write_takes;
        @(posedge i_clk_sys) disable iff (i_reset)
        (i_route_wr && !pin_reset) |=> o_route_cfg == $past(i_route_data);
    endproperty
    a_write_takes: assert property (p_write_takes) else $error("write lost");

    property p_sda_claim;
        @(posedge i_clk_sys) disable iff (i_reset)
        o_eeprom_mode ##1 o_eeprom_mode |-> o_pin[`MP_SDA_PIN] == 1'b0 &&
            o_pin_oe[`MP_SDA_PIN] == $past(i_sda_drive_low);
    endproperty
    a_sda_claim: assert property (p_sda_claim) else $error("sda not claimed");

    property p_scl_claim;
        @(posedge i_clk_sys) disable iff (i_reset)
        o_eeprom_mode ##1 o_eeprom_mode |-> o_pin[`MP_SCL_PIN] == 1'b0 &&
            o_pin_oe[`MP_SCL_PIN] == $past(i_scl_drive_low);
    endproperty
    a_scl_claim: assert property (p_scl_claim) else $error("scl not claimed");

    property p_detect_capture;
        @(posedge i_clk_sys) disable iff (i_reset)
        (global_rst_q && !global_rst) |=>
            o_eeprom_mode == $past(filt[`MP_SYNC_DETECT_A] && filt[`MP_SYNC_DETECT_B]);
    endproperty
    a_detect_capture: assert property (p_detect_capture) else $error("detect miss");

    property p_pin6_only;
        @(posedge i_clk_sys) disable iff (i_reset)
        (o_route_cfg.sel[6] inside {multi_pin_pkg::FN_GEN_OUT, multi_pin_pkg::FN_GPE})
            |=> !o_pin_oe[6];
    endproperty
    a_pin6_only: assert property (p_pin6_only) else $error("pin 6 illegal drive");

    property p_ring_pme;
        @(posedge i_clk_sys) disable iff (i_reset)
        ##1 o_ring_pme == ($past(o_route_cfg.pme_select) ? $past(i_pme) : $past(i_src.ring));
    endproperty
    a_ring_pme: assert property (p_ring_pme) else $error("ring/pme wrong");

    property p_inta_drive;
        @(posedge i_clk_sys) disable iff (i_reset)
        (o_route_cfg.sel[0] == multi_pin_pkg::FN_INTA && !o_eeprom_mode)
            |=> o_pin[0] == 1'b0 && o_pin_oe[0] == $past(i_src.inta);
    endproperty
    a_inta_drive: assert property (p_inta_drive) else $error("inta drive wrong");

endmodule : multi_pin_router

// ---- pin_side_model.sv ----
/*
 * Board side of the seven multifunction pins: pull-ups, other drivers
 * and a serial EEPROM target that can acknowledge on the data line.
 * Assumes the router's enable is high while it drives a pin.
 */
`timescale 1ns/10ps

module pin_side_model (
    // router side
    input wire logic [6:0] i_pin_out,
    input wire logic [6:0] i_pin_oe,
    input wire logic i_eeprom_mode,
    // board drivers
    input wire logic [6:0] i_ext_val,
    input wire logic [6:0] i_ext_oe,
    input wire logic i_ack,
    // resolved wire level
    output logic [6:0] o_level
);
    always_comb
    begin
        for (int p = 0; p < 7; p++)
        begin
            if (i_pin_oe[p])
                o_level[p] = i_pin_out[p];
            else if (i_ext_oe[p])
                o_level[p] = i_ext_val[p];
            else
                o_level[p] = 1'b1; // released lines rest on pull-ups
        end
        // open drain: the target wins low over anything else
        if (i_eeprom_mode && i_ack)
            o_level[1] = 1'b0;
    end
endmodule : pin_side_model

// ---- testbench.sv ----
/*
 * Self-checking bench for the multifunction pin router.
 * Assumes the router and pin_side_model are compiled before it.
 */
`timescale 1ns/10ps

module testbench;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic i_clk_sys, i_reset, i_global_reset, i_bus_reset, i_suspend;
    logic i_serial_detect_a, i_serial_detect_b, i_route_wr;
    multi_pin_pkg::route_cfg_t i_route_data, o_route_cfg;
    multi_pin_pkg::fn_src_t i_src;
    logic [4:0] o_general_input;
    logic o_pci_lock, o_serirq_in, o_clkrun_in, o_eeprom_mode, o_sda_in, o_scl_in;
    logic i_load_done, i_sda_drive_low, i_scl_drive_low, i_pme;
    logic [6:0] i_pin, o_pin, o_pin_oe, ext_val, ext_oe;
    logic i_card_speaker_input, i_card_audio_input, o_speaker_output, o_ring_pme;
    logic ack;
    int err_count = 0;
    int n_compared = 0;
    // legal function codes of each pin, one bit per code
    logic [15:0] legal [7] = '{16'h00FF, 16'h01FD, 16'h03FD, 16'h0801,
                               16'h07FD, 16'h01FD, 16'h1001};

    multi_pin_router multi_pin_router_i (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
        .i_global_reset(i_global_reset), .i_bus_reset(i_bus_reset), .i_suspend(i_suspend),
        .i_serial_detect_a(i_serial_detect_a), .i_serial_detect_b(i_serial_detect_b),
        .i_route_wr(i_route_wr), .i_route_data(i_route_data), .o_route_cfg(o_route_cfg),
        .i_src(i_src), .o_general_input(o_general_input), .o_pci_lock(o_pci_lock),
        .o_serirq_in(o_serirq_in), .o_clkrun_in(o_clkrun_in), .i_load_done(i_load_done),
        .i_sda_drive_low(i_sda_drive_low), .i_scl_drive_low(i_scl_drive_low), .i_pme(i_pme),
        .o_eeprom_mode(o_eeprom_mode), .o_sda_in(o_sda_in), .o_scl_in(o_scl_in),
        .i_pin(i_pin), .o_pin(o_pin), .o_pin_oe(o_pin_oe),
        .i_card_speaker_input(i_card_speaker_input), .i_card_audio_input(i_card_audio_input),
        .o_speaker_output(o_speaker_output), .o_ring_pme(o_ring_pme));
    pin_side_model pin_side_model_i (.i_pin_out(o_pin), .i_pin_oe(o_pin_oe),
        .i_eeprom_mode(o_eeprom_mode), .i_ext_val(ext_val), .i_ext_oe(ext_oe),
        .i_ack(ack), .o_level(i_pin));

    initial
    begin
        i_clk_sys = 1'b0;
        forever #2 i_clk_sys = ~i_clk_sys;
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk_sys);
    endtask : tick

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        @(negedge i_clk_sys);
        n_compared++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
        // hand back on a rising edge so callers drive inputs there
        @(posedge i_clk_sys);
    endtask : check

    task automatic route(input multi_pin_pkg::route_cfg_t cfg);
        tick(1);
        i_route_wr <= 1'b1;
        i_route_data <= cfg;
        tick(1);
        i_route_wr <= 1'b0;
        tick(3);
    endtask : route

    task automatic print_verdict();
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : print_verdict

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_defaults();
        check(o_route_cfg.sel[3], multi_pin_pkg::FN_SERIRQ);
        check(o_route_cfg.sel[6], multi_pin_pkg::FN_CLKRUN);
        check(o_pin_oe, 7'h00);
        $display("test defaults done");
    endtask : t_defaults

    task automatic t_functions();
        multi_pin_pkg::route_cfg_t cfg;
        logic drv;
        i_src <= '1;
        for (int p = 0; p < 7; p++)
            for (int c = 0; c < 16; c++)
            begin
                cfg = '0;
                for (int q = 0; q < 7; q++)
                    cfg.sel[q] = multi_pin_pkg::FN_GEN_IN;
                cfg.sel[p] = multi_pin_pkg::mux_fn_t'(c);
                route(cfg);
                drv = legal[p][c] && c != 2 && c != 10;
                check(o_pin_oe[p], drv);
                if (drv)
                    check(o_pin[p], c != 1);
                check(o_pin_oe & ~(7'h01 << p), 7'h00);
            end
        i_src <= '0;
        $display("test functions done");
    endtask : t_functions

    task automatic t_inputs();
        multi_pin_pkg::route_cfg_t cfg;
        cfg = '0;
        for (int q = 0; q < 7; q++)
            cfg.sel[q] = multi_pin_pkg::FN_GEN_IN;
        route(cfg);
        ext_oe <= 7'h7F;
        ext_val <= 7'h35;
        tick(7);
        check(o_general_input, 5'h1D);
        cfg.sel[3] = multi_pin_pkg::FN_SERIRQ;
        cfg.sel[4] = multi_pin_pkg::FN_LOCK;
        cfg.sel[6] = multi_pin_pkg::FN_CLKRUN;
        route(cfg);
        ext_val <= 7'h00;
        tick(7);
        check({o_pci_lock, o_serirq_in, o_clkrun_in}, 3'h0);
        ext_oe <= 7'h00;
        tick(7);
        check({o_pci_lock, o_serirq_in, o_clkrun_in}, 3'h7);
        $display("test inputs done");
    endtask : t_inputs

    task automatic t_misc();
        multi_pin_pkg::route_cfg_t cfg;
        for (int k = 0; k < 4; k++)
        begin
            tick(1);
            i_card_speaker_input <= k[0];
            i_card_audio_input <= k[1];
            tick(7);
            check(o_speaker_output, k[0] ^ k[1]);
        end
        cfg = o_route_cfg;
        for (int k = 0; k < 4; k++)
        begin
            cfg.pme_select = k[0];
            route(cfg);
            i_pme <= k[1];
            i_src.ring <= ~k[1];
            tick(3);
            check(o_ring_pme, k[0] ? k[1] : !k[1]);
        end
        $display("test misc done");
    endtask : t_misc

    task automatic t_suspend();
        multi_pin_pkg::route_cfg_t cfg;
        cfg = o_route_cfg;
        cfg.sel[0] = multi_pin_pkg::FN_GEN_OUT;
        route(cfg);
        i_suspend <= 1'b1;
        tick(6);
        i_global_reset <= 1'b1;
        tick(8);
        check(o_route_cfg.sel[0], multi_pin_pkg::FN_GEN_OUT);
        i_global_reset <= 1'b0;
        tick(6);
        i_suspend <= 1'b0;
        tick(6);
        i_bus_reset <= 1'b1;
        tick(8);
        check(o_route_cfg.sel[0], multi_pin_pkg::FN_GEN_IN);
        i_bus_reset <= 1'b0;
        check(o_eeprom_mode, 1'b0);
        $display("test suspend done");
    endtask : t_suspend

    task automatic t_eeprom();
        i_serial_detect_a <= 1'b1;
        i_serial_detect_b <= 1'b1;
        tick(6);
        i_global_reset <= 1'b1;
        tick(8);
        i_global_reset <= 1'b0;
        tick(8);
        check(o_eeprom_mode, 1'b1);
        i_sda_drive_low <= 1'b1;
        i_scl_drive_low <= 1'b1;
        tick(3);
        check({o_pin_oe[1], o_pin[1], o_pin_oe[4], o_pin[4]}, 4'hA);
        i_sda_drive_low <= 1'b0;
        i_scl_drive_low <= 1'b0;
        tick(8);
        check({o_sda_in, o_scl_in}, 2'h3);
        ack <= 1'b1;
        tick(8);
        check({o_sda_in, o_scl_in}, 2'h1);
        ack <= 1'b0;
        i_load_done <= 1'b1;
        tick(1);
        i_load_done <= 1'b0;
        tick(3);
        check(o_eeprom_mode, 1'b0);
        $display("test eeprom done");
    endtask : t_eeprom

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial
    begin
        i_reset = 1'b1;
        {i_global_reset, i_bus_reset, i_suspend, i_route_wr, ack} = '0;
        {i_serial_detect_a, i_serial_detect_b, i_load_done, i_pme} = '0;
        {i_sda_drive_low, i_scl_drive_low} = '0;
        {i_card_speaker_input, i_card_audio_input} = '0;
        i_route_data = '0;
        i_src = '0;
        ext_val = '0;
        ext_oe = '0;
        tick(2);
        i_reset <= 1'b0;
        t_defaults();
        t_functions();
        t_inputs();
        t_misc();
        t_suspend();
        t_eeprom();
        print_verdict();
    end

    initial
    begin
        // about 1000 cycles of tests; allow many times that
        #40000;
        err_count++;
        print_verdict();
    end
endmodule : testbench
